// ### fem_regs.svh
// constants for the framing error and mode control block
`ifndef FEM_REGS_SVH
`define FEM_REGS_SVH
`define FEM_CODE_W         3
`define FEM_CODE_NONE      3'h0
`define FEM_CODE_LOST      3'h1
`define FEM_CODE_CRC       3'h2
`define FEM_CODE_MARKER    3'h3
`define FEM_CODE_BADSETUP  3'h4
`define FEM_SEG_W          16
`endif

// ### fem_pkg.sv
// types shared by both ends of the framing error and mode control link
package fem_pkg;
   typedef enum logic [1:0]
   {
      FEM_STREAMING = 2'b00,
      FEM_FRAMED    = 2'b01,
      FEM_HALTED    = 2'b10,
      FEM_CLOSED    = 2'b11
   } fem_state_t;
endpackage

// ### fem_link_if.sv
// link between framing device and upper placement layer
`timescale 1ns/1ps
`default_nettype none
`include "fem_regs.svh"
interface fem_link_if;
   // device to upper layer
   logic                    errValid;
   logic [`FEM_CODE_W-1:0]  errCode;
   logic                    fpduValid;
   logic [`FEM_SEG_W-1:0]   fpduData;
   logic                    gracefulClose;
   logic                    rxHalted;
   logic                    txReady;
   logic                    framedMode;
   // upper layer to device
   logic                    enableFramed;
   logic                    isResponder;
   logic                    lastStreamValid;
   logic [`FEM_SEG_W-1:0]   lastStreamData;
   logic                    closeRxHalf;
   logic                    closeTxHalf;
   logic                    txValid;
   logic [`FEM_SEG_W-1:0]   txData;

   modport device (output errValid, errCode, fpduValid, fpduData, gracefulClose, rxHalted, txReady, framedMode,
                   input enableFramed, isResponder, lastStreamValid, lastStreamData, closeRxHalf, closeTxHalf,
                   txValid, txData);
   modport upper  (input errValid, errCode, fpduValid, fpduData, gracefulClose, rxHalted, txReady, framedMode,
                   output enableFramed, isResponder, lastStreamValid, lastStreamData, closeRxHalf, closeTxHalf,
                   txValid, txData);
endinterface
`default_nettype wire

// ### fem_err_prio.sv
// priority encoder picking one error code from the detected conditions
`timescale 1ns/1ps
`default_nettype none
`include "fem_regs.svh"
module fem_err_prio
   import fem_pkg::*;
(
   // detected conditions
   input  wire logic                   lost,
   input  wire logic                   badSetup,
   input  wire logic                   crcBad,
   input  wire logic                   markerBad,
   input  wire logic                   dropOpt,
   // chosen report
   output logic                        report,
   output logic [`FEM_CODE_W-1:0]      code
);
   // connection-ending errors win; dropped segments report nothing
   always_comb
   begin
      report = 1'b0;
      code   = `FEM_CODE_NONE;
      if (lost)
      begin
         report = 1'b1;
         code   = `FEM_CODE_LOST;
      end
      else if (badSetup)
      begin
         report = 1'b1;
         code   = `FEM_CODE_BADSETUP;
      end
      else if (crcBad && !dropOpt)
      begin
         report = 1'b1;
         code   = `FEM_CODE_CRC;
      end
      else if (markerBad && !dropOpt)
      begin
         report = 1'b1;
         code   = `FEM_CODE_MARKER;
      end
   end
endmodule
`default_nettype wire

// ### fem_device.sv
// framing device end: error detection, receive halt and mode control
// ----------------------------------------------------------------
// What this block does
// - tcp loss events report code 1
// - crc mismatch reports code 2
// - valid crc, marker start mismatch reports code 3
// - check markers on gap fill or revisit
// - in-order or extra markers may skip check
// - bad setup frame reports 4, closes tcp
// - upper layer treats code 4 as 1
// - optional silent drop of crc/marker errors
// - no fpdu delivery after any reported error
// - crc/marker errors leave tcp open
// - transmit half stays usable after crc/marker error
// - each half ends when upper closes it
// - indicate graceful close upward
// - detect errors and pass numeric code
// - unvalidated data at boundary reports error
// - upper enables framed mode when streaming done
// - responder enters framed, sends last stream
// - initiator receives last stream before framing
// - responder enable may carry last stream message
// - keep tcp recovery across mode switch
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "fem_regs.svh"
module fem_device
   import fem_pkg::*;
#(
   parameter bit SILENT_DROP = 1'b0
)
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset,
   // link to upper layer
   fem_link_if.device                 link,
   // tcp side receive events
   input  wire logic                  tcpTimeout,
   input  wire logic                  tcpRetriesOut,
   input  wire logic                  tcpRstRx,
   input  wire logic                  tcpFinRx,
   input  wire logic                  segValid,
   input  wire logic [`FEM_SEG_W-1:0] segData,
   input  wire logic                  segInOrder,
   input  wire logic                  segGapFill,
   input  wire logic                  segCrcOk,
   input  wire logic                  segFormatOk,
   input  wire logic                  markersOn,
   input  wire logic                  markerHit,
   input  wire logic                  markerRevisit,
   input  wire logic [`FEM_SEG_W-1:0] markerStart,
   input  wire logic [`FEM_SEG_W-1:0] lengthStart,
   input  wire logic                  setupFrameValid,
   input  wire logic                  setupFrameOk,
   // tcp side controls
   output logic                       tcpClose,
   output logic                       tcpTxValid,
   output logic [`FEM_SEG_W-1:0]      tcpTxData,
   output logic                       tcpTxHalfClose
);
   // ----------------------------------------------------------------
   // error detection
   // ----------------------------------------------------------------
   fem_state_t              rxState_reg;
   logic                    txOpen_reg;
   logic                    lostEvt;
   logic                    badSetup;
   logic                    crcBad;
   logic                    markerBad;
   logic                    doCheck;
   logic                    report;
   logic [`FEM_CODE_W-1:0]  code;
   logic                    rxLive;

   assign rxLive   = (rxState_reg == FEM_FRAMED);
   assign lostEvt  = (tcpTimeout | tcpRetriesOut | tcpRstRx | tcpFinRx) &&
                     rxState_reg != FEM_CLOSED;
   assign badSetup = setupFrameValid && !setupFrameOk && rxState_reg != FEM_CLOSED;
   // unformatted data at the boundary counts as a crc failure
   assign crcBad   = rxLive && segValid && (!segCrcOk || !segFormatOk);
   // in-order marker hits skip the compare unless gap fill or revisit; cheap and allowed
   assign doCheck  = (segGapFill || markerRevisit || (markerHit && !segInOrder));
   assign markerBad = rxLive && segValid && segCrcOk && segFormatOk && markersOn &&
                      doCheck && (markerStart != lengthStart);

   fem_err_prio uPrio
   (
      .lost      (lostEvt),
      .badSetup  (badSetup),
      .crcBad    (crcBad),
      .markerBad (markerBad),
      .dropOpt   (SILENT_DROP),
      .report    (report),
      .code      (code)
   );

   // ----------------------------------------------------------------
   // error report strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         link.errValid <= 1'b0;
         link.errCode  <= `FEM_CODE_NONE;
      end
      else
      begin
         link.errValid <= report;
         if (report)
            link.errCode <= code;
      end
   end

   // ----------------------------------------------------------------
   // receive half state
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
         rxState_reg <= FEM_STREAMING;
      else
      begin
         unique case (rxState_reg)
            FEM_STREAMING:
            begin
               if (report)
                  rxState_reg <= FEM_HALTED;
               else if (link.enableFramed)
                  rxState_reg <= FEM_FRAMED;
            end
            FEM_FRAMED:
            begin
               if (link.closeRxHalf)
                  rxState_reg <= FEM_CLOSED;
               else if (report)
                  rxState_reg <= FEM_HALTED;
            end
            FEM_HALTED:
            begin
               if (link.closeRxHalf)
                  rxState_reg <= FEM_CLOSED;
            end
            FEM_CLOSED:
               rxState_reg <= FEM_CLOSED;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         link.rxHalted   <= 1'b0;
         link.framedMode <= 1'b0;
      end
      else
      begin
         link.rxHalted   <= (rxState_reg == FEM_HALTED) || report;
         link.framedMode <= (rxState_reg == FEM_FRAMED) || (rxState_reg == FEM_STREAMING && link.enableFramed);
      end
   end

   // ----------------------------------------------------------------
   // fpdu delivery
   // ----------------------------------------------------------------
   // tcp below already reorders and retransmits; this only gates delivery
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         link.fpduValid <= 1'b0;
         link.fpduData  <= '0;
      end
      else
      begin
         link.fpduValid <= rxLive && segValid && !report && !crcBad && !markerBad;
         if (segValid)
            link.fpduData <= segData;
      end
   end

   // ----------------------------------------------------------------
   // graceful close and tcp close
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         link.gracefulClose <= 1'b0;
         tcpClose           <= 1'b0;
      end
      else
      begin
         link.gracefulClose <= tcpFinRx;
         // crc and marker errors never close the connection
         tcpClose <= badSetup || (link.closeRxHalf && link.closeTxHalf);
      end
   end

   // ----------------------------------------------------------------
   // transmit half
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
         txOpen_reg <= 1'b1;
      else if (link.closeTxHalf || badSetup || lostEvt)
         txOpen_reg <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tcpTxValid     <= 1'b0;
         tcpTxData      <= '0;
         tcpTxHalfClose <= 1'b0;
         link.txReady   <= 1'b0;
      end
      else
      begin
         // crc and marker errors leave transmit alone so diagnostics still go out; loss and bad setup close it
         link.txReady   <= txOpen_reg && !link.closeTxHalf;
         tcpTxHalfClose <= link.closeTxHalf && txOpen_reg;
         if (rxState_reg == FEM_STREAMING && link.enableFramed && link.isResponder && link.lastStreamValid)
         begin
            tcpTxValid <= txOpen_reg;
            tcpTxData  <= link.lastStreamData;
         end
         else
         begin
            tcpTxValid <= txOpen_reg && link.txValid;
            tcpTxData  <= link.txData;
         end
      end
   end
endmodule
`default_nettype wire

// ### fem_upper.sv
// upper placement layer end: mode enable, error handling, teardown
`timescale 1ns/1ps
`default_nettype none
`include "fem_regs.svh"
module fem_upper
   import fem_pkg::*;
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset,
   // link to device
   fem_link_if.upper                  link,
   // user side
   input  wire logic                  userResponder,
   input  wire logic                  userStreamDone,
   input  wire logic                  userLastValid,
   input  wire logic [`FEM_SEG_W-1:0] userLastData,
   input  wire logic                  userTxValid,
   input  wire logic [`FEM_SEG_W-1:0] userTxData,
   input  wire logic                  userTeardown,
   output logic                       userRxValid,
   output logic [`FEM_SEG_W-1:0]      userRxData,
   output logic                       userConnLost,
   output logic                       userRxError
);
   logic enabled_reg;

   // ----------------------------------------------------------------
   // mode switch
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         enabled_reg         <= 1'b0;
         link.enableFramed   <= 1'b0;
         link.isResponder    <= 1'b0;
         link.lastStreamValid <= 1'b0;
         link.lastStreamData <= '0;
      end
      else
      begin
         link.isResponder <= userResponder;
         // one pulse only once streaming input is done
         link.enableFramed    <= !enabled_reg && userStreamDone;
         link.lastStreamValid <= !enabled_reg && userStreamDone && userResponder && userLastValid;
         link.lastStreamData  <= userLastData;
         if (userStreamDone)
            enabled_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // errors and teardown
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         userConnLost     <= 1'b0;
         userRxError      <= 1'b0;
         link.closeRxHalf <= 1'b0;
         link.closeTxHalf <= 1'b0;
      end
      else
      begin
         if (link.errValid && (link.errCode == `FEM_CODE_LOST || link.errCode == `FEM_CODE_BADSETUP))
            userConnLost <= 1'b1;
         if (link.errValid)
            userRxError <= 1'b1;
         if (link.gracefulClose || (link.errValid && link.errCode != `FEM_CODE_NONE))
            link.closeRxHalf <= 1'b1;
         if (userTeardown)
            link.closeTxHalf <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // data
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         userRxValid  <= 1'b0;
         userRxData   <= '0;
         link.txValid <= 1'b0;
         link.txData  <= '0;
      end
      else
      begin
         userRxValid  <= link.fpduValid;
         userRxData   <= link.fpduData;
         link.txValid <= userTxValid && link.txReady;
         link.txData  <= userTxData;
      end
   end
endmodule
`default_nettype wire

// ### fem_link_properties.sv
// concurrent checks on the link between framing device and upper layer
`timescale 1ns/1ps
`default_nettype none
`include "fem_regs.svh"
module fem_link_properties
   import fem_pkg::*;
(
   // clock and reset
   input wire logic                   clk,
   input wire logic                   reset,
   // link signals
   input wire logic                   errValid,
   input wire logic [`FEM_CODE_W-1:0] errCode,
   input wire logic                   fpduValid,
   input wire logic                   gracefulClose,
   input wire logic                   rxHalted,
   input wire logic                   txReady,
   input wire logic                   framedMode,
   input wire logic                   enableFramed,
   input wire logic                   closeRxHalf,
   input wire logic                   closeTxHalf
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   chk_err_strobe_short:
      assert property (errValid |=> !errValid) else $error("error strobe too long");
   chk_code_known:
      assert property (errValid |-> errCode inside {3'h1, 3'h2, 3'h3, 3'h4}) else $error("bad error code");
   chk_halt_on_err:
      assert property (errValid |-> rxHalted) else $error("no halt with error");
   chk_no_fpdu_halted:
      assert property (rxHalted |-> !fpduValid) else $error("delivery while halted");
   chk_halt_sticky:
      assert property (rxHalted && !closeRxHalf |=> rxHalted) else $error("halt dropped early");
   chk_err_closes_rx:
      assert property (errValid |=> closeRxHalf) else $error("rx half not closed");
   chk_fin_closes_rx:
      assert property (gracefulClose |=> closeRxHalf) else $error("close not seen upward");
   chk_framed_enter:
      assert property (enableFramed |=> framedMode) else $error("framed mode not entered");
   chk_enable_pulse:
      assert property (enableFramed |=> !enableFramed) else $error("enable held");
   chk_tx_kept_open:
      assert property (txReady && !closeTxHalf && errValid && errCode inside {3'h2, 3'h3} |=> txReady)
         else $error("tx half lost on rx error");
   // main scenarios
   cov_crc: cover property (errValid && errCode == 3'h2);
   cov_setup: cover property (errValid && errCode == 3'h4);
   cov_framed: cover property (enableFramed);
   cov_fin: cover property (gracefulClose);
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the framing device and upper layer pair
`timescale 1ns/1ps
`default_nettype none
`include "fem_regs.svh"
module tb_top
   import fem_pkg::*;
;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic                  clk = 1'b0;
   logic                  reset;
   logic                  tcpTimeout, tcpRetriesOut, tcpRstRx, tcpFinRx, segValid, segInOrder, segGapFill;
   logic                  segCrcOk, segFormatOk, markersOn, markerHit, markerRevisit, setupFrameValid;
   logic                  setupFrameOk, userResponder, userStreamDone, userLastValid, userTxValid;
   logic                  userTeardown, tcpClose, tcpTxValid, tcpTxHalfClose;
   logic                  userRxValid, userConnLost, userRxError;
   logic [`FEM_SEG_W-1:0] segData, markerStart, lengthStart, userLastData, userTxData, tcpTxData, userRxData;
   int                    bad_count = 0;
   int                    checks = 0;

   fem_link_if link ();
   fem_link_if linkDrop ();
   fem_device i_fem_device (.clk(clk), .reset(reset), .link(link), .tcpTimeout(tcpTimeout),
      .tcpRetriesOut(tcpRetriesOut), .tcpRstRx(tcpRstRx), .tcpFinRx(tcpFinRx), .segValid(segValid),
      .segData(segData), .segInOrder(segInOrder), .segGapFill(segGapFill), .segCrcOk(segCrcOk),
      .segFormatOk(segFormatOk), .markersOn(markersOn), .markerHit(markerHit), .markerRevisit(markerRevisit),
      .markerStart(markerStart), .lengthStart(lengthStart), .setupFrameValid(setupFrameValid),
      .setupFrameOk(setupFrameOk), .tcpClose(tcpClose), .tcpTxValid(tcpTxValid), .tcpTxData(tcpTxData),
      .tcpTxHalfClose(tcpTxHalfClose));
   // second device with silent drop; same tcp side, upper controls copied from the first link
   fem_device #(.SILENT_DROP(1'b1)) i_fem_device_drop (.clk(clk), .reset(reset), .link(linkDrop),
      .tcpTimeout(tcpTimeout), .tcpRetriesOut(tcpRetriesOut), .tcpRstRx(tcpRstRx), .tcpFinRx(tcpFinRx),
      .segValid(segValid), .segData(segData), .segInOrder(segInOrder), .segGapFill(segGapFill),
      .segCrcOk(segCrcOk), .segFormatOk(segFormatOk), .markersOn(markersOn), .markerHit(markerHit),
      .markerRevisit(markerRevisit), .markerStart(markerStart), .lengthStart(lengthStart),
      .setupFrameValid(setupFrameValid), .setupFrameOk(setupFrameOk), .tcpClose(), .tcpTxValid(),
      .tcpTxData(), .tcpTxHalfClose());
   assign linkDrop.enableFramed    = link.enableFramed;
   assign linkDrop.isResponder     = link.isResponder;
   assign linkDrop.lastStreamValid = link.lastStreamValid;
   assign linkDrop.lastStreamData  = link.lastStreamData;
   assign linkDrop.closeRxHalf     = link.closeRxHalf;
   assign linkDrop.closeTxHalf     = link.closeTxHalf;
   assign linkDrop.txValid         = link.txValid;
   assign linkDrop.txData          = link.txData;
   fem_upper i_fem_upper (.clk(clk), .reset(reset), .link(link), .userResponder(userResponder),
      .userStreamDone(userStreamDone), .userLastValid(userLastValid), .userLastData(userLastData),
      .userTxValid(userTxValid), .userTxData(userTxData), .userTeardown(userTeardown),
      .userRxValid(userRxValid), .userRxData(userRxData), .userConnLost(userConnLost),
      .userRxError(userRxError));
   fem_link_properties i_fem_link_properties (.clk(clk), .reset(reset), .errValid(link.errValid),
      .errCode(link.errCode), .fpduValid(link.fpduValid), .gracefulClose(link.gracefulClose),
      .rxHalted(link.rxHalted), .txReady(link.txReady), .framedMode(link.framedMode),
      .enableFramed(link.enableFramed), .closeRxHalf(link.closeRxHalf), .closeTxHalf(link.closeTxHalf));

   always #4 clk = ~clk;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task finish_test;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input bit ok, input string m);
      checks++;
      if (!ok)
      begin
         bad_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   function automatic logic sig(input int s);
      case (s)
         0: sig = link.errValid;
         1: sig = userRxValid;
         2: sig = tcpTxValid;
         3: sig = tcpClose;
         4: sig = tcpTxHalfClose;
         default: sig = link.framedMode;
      endcase
   endfunction

   // bounded wait; a pulse already up counts
   task wt(input int s);
      int n;
      for (n = 0; n < 20; n++)
      begin
         if (sig(s) === 1'b1)
            break;
         @(negedge clk);
      end
      if (n == 20)
      begin
         bad_count++;
         $display("[ERR] %0t wait ran out", $time);
         finish_test();
      end
   endtask

   task nv(input int s, input int c);
      repeat (c)
      begin
         chk(sig(s) !== 1'b1, "unexpected strobe");
         @(negedge clk);
      end
   endtask

   // full reset so sticky halt and close state start clean
   task rst;
      reset = 1'b1;
      {tcpTimeout, tcpRetriesOut, tcpRstRx, tcpFinRx, segValid, segInOrder, segGapFill, segCrcOk} = '0;
      {segFormatOk, markersOn, markerHit, markerRevisit, setupFrameValid, setupFrameOk} = '0;
      {userResponder, userStreamDone, userLastValid, userTxValid, userTeardown} = '0;
      {segData, markerStart, lengthStart, userLastData, userTxData} = '0;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
   endtask

   task seg(input bit crc, input bit gap, input bit rev, input bit ord, input logic [15:0] ms);
      {segValid, segFormatOk, markersOn, markerHit} = 4'hF;
      {segCrcOk, segGapFill, markerRevisit, segInOrder} = {crc, gap, rev, ord};
      segData = 16'h1234;
      markerStart = ms;
      lengthStart = 16'h0040;
      @(negedge clk);
      {segValid, segGapFill, markerRevisit} = 3'h0;
   endtask

   task go_framed(input bit resp);
      {userResponder, userStreamDone, userLastValid} = {resp, 2'h3};
      userLastData = 16'hA5C3;
      wt(5);
      chk(tcpTxValid === resp, "last stream send wrong");
      chk(!resp || tcpTxData === 16'hA5C3, "last stream word wrong");
      chk(link.framedMode === 1'b1, "not framed");
      {userStreamDone, userLastValid} = 2'h0;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task sc_mode;
      rst();
      go_framed(1'b1);
      seg(1'b1, 1'b0, 1'b0, 1'b1, 16'h0040);
      wt(1);
      chk(userRxData === 16'h1234, "delivered word wrong");
      seg(1'b1, 1'b0, 1'b0, 1'b1, 16'h0080);
      nv(0, 3);
      // good crc but not a well-formed frame at the boundary
      {segValid, segFormatOk} = 2'b10;
      @(negedge clk);
      segValid = 1'b0;
      wt(0);
      chk(link.errCode === `FEM_CODE_CRC, "unformatted data not reported");
   endtask

   task sc_crc;
      rst();
      go_framed(1'b1);
      seg(1'b0, 1'b0, 1'b0, 1'b1, 16'h0040);
      wt(0);
      chk(link.errCode === `FEM_CODE_CRC, "crc code wrong");
      chk(linkDrop.errValid === 1'b0 && linkDrop.rxHalted === 1'b0 && linkDrop.fpduValid === 1'b0,
          "dropped crc error reported");
      nv(3, 6);
      seg(1'b1, 1'b0, 1'b0, 1'b1, 16'h0040);
      nv(1, 4);
      chk(userRxError === 1'b1, "error not passed up");
      userTxValid = 1'b1;
      userTxData = 16'h5A0F;
      @(negedge clk);
      userTxValid = 1'b0;
      wt(2);
      chk(tcpTxData === 16'h5A0F, "tx word after error wrong");
   endtask

   task sc_marker;
      // in-order segments so only gap fill or revisit trigger, then an out-of-order marker hit
      for (int k = 0; k < 3; k++)
      begin
         rst();
         go_framed(1'b1);
         seg(1'b1, k == 0, k == 1, k != 2, 16'h0080);
         wt(0);
         chk(link.errCode === `FEM_CODE_MARKER, "marker code wrong");
         chk(linkDrop.errValid === 1'b0, "dropped marker error reported");
      end
   endtask

   task sc_lost;
      for (int e = 0; e < 4; e++)
      begin
         rst();
         go_framed(1'b1);
         {tcpTimeout, tcpRetriesOut, tcpRstRx, tcpFinRx} = 4'h8 >> e;
         @(negedge clk);
         {tcpTimeout, tcpRetriesOut, tcpRstRx, tcpFinRx} = 4'h0;
         wt(0);
         chk(link.errCode === `FEM_CODE_LOST, "lost code wrong");
         chk(link.gracefulClose === (e == 3), "close notice wrong");
         repeat (2) @(negedge clk);
         chk(userConnLost === 1'b1, "loss not seen upward");
      end
   endtask

   task sc_setup;
      rst();
      setupFrameValid = 1'b1;
      @(negedge clk);
      setupFrameValid = 1'b0;
      wt(0);
      chk(link.errCode === `FEM_CODE_BADSETUP, "setup code wrong");
      chk(tcpClose === 1'b1, "tcp not closed");
      repeat (2) @(negedge clk);
      chk(userConnLost === 1'b1, "setup loss not seen");
   endtask

   task sc_teardown;
      rst();
      // initiator: stream input already done before the enable
      go_framed(1'b0);
      userTeardown = 1'b1;
      wt(4);
      repeat (2) @(negedge clk);
      chk(link.txReady === 1'b0, "tx half still open");
   endtask

   initial
   begin
      rst();
      sc_mode();
      sc_crc();
      sc_marker();
      sc_lost();
      sc_setup();
      sc_teardown();
      finish_test();
   end
endmodule
`default_nettype wire
